// [src/pin_select_consts.svh]
// Register offsets, field positions, reset values and address map constants of the pin function selector.
`ifndef PIN_SELECT_CONSTS_SVH
`define PIN_SELECT_CONSTS_SVH

`define ADDR_W            8
`define REG_PORT7B2_CTRL  8'h00
`define REG_PORT8B4_CTRL  8'h04
`define REG_GPIO_OUT      8'h08
`define REG_PIN_STATUS    8'h0C
`define REG_RAM_SIZE      8'h10

`define SEL_W             4
`define SEL_ENABLE_BIT    3
`define SEL_RST           4'h0
`define GPIO_RST          2'h0

`define STAT_PORT7_IN     0
`define STAT_PORT8_IN     1
`define STAT_TEST_MODE    2
`define STAT_DEBUG_POS_C  3
`define STAT_DEBUG_POS_D  4

`define RAM_KB_W          8
`define PRAM_KB_RST       8'h20
`define DRAM_KB_RST       8'h10
`define MEM_ADDR_W        24
`define PRAM_BASE         24'hE00000
`define DRAM_END          24'h00DFFF
`define DRAM_END_NEXT     24'h00E000

`define SYNC_RST          3'h4
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// [src/pin_select_pkg.sv]
// Types shared by the pin function selector modules.
package pin_select_pkg;
   `include "pin_select_consts.svh"
   typedef logic [`SEL_W-1:0]      sel_field_t;
   typedef logic [`RAM_KB_W-1:0]   ram_kb_t;
   typedef logic [`MEM_ADDR_W-1:0] mem_addr_t;
endpackage

// [src/pin_out_select.sv]
// Output source selector for one general-purpose pin.
`timescale 1ns/1ps
module pin_out_select
   import pin_select_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       reset,
   // Software selection and alternate sources.
   input  wire sel_field_t selField,
   input  wire logic [3:0] altOutputs,
   // Hardware ownership of the pin.
   input  wire logic       hwOwned,
   input  wire logic       hwValue,
   input  wire logic       hwDrive,
   // Pad side.
   output logic            pinOut,
   output logic            pinOe_n
);

   // Bit 2 of the field plays no part in choosing the source.
   always_ff @(posedge clk) begin
      if (reset) begin
         pinOut  <= 1'b0;
         pinOe_n <= 1'b1;
      end else if (hwOwned) begin
         pinOut  <= hwValue;                                    // [RULE5]
         pinOe_n <= !hwDrive;                                   // [RULE5]
      end else if (selField[`SEL_ENABLE_BIT]) begin
         pinOut  <= altOutputs[selField[1:0]];                  // [RULE4] [RULE11]
         pinOe_n <= 1'b0;
      end else begin
         pinOut  <= 1'b0;
         pinOe_n <= 1'b1;                                       // [RULE11]
      end
   end

   hwWins_a: assert property (@(posedge clk) disable iff (reset) // [RULE5]
      hwOwned |=> (pinOut == $past(hwValue)) && (pinOe_n == !$past(hwDrive)))
      else $error("Hardware-owned pin did not follow its owner.");

   selOne_a: assert property (@(posedge clk) disable iff (reset) // [RULE4]
      (!hwOwned && selField[3] && selField[1:0] == 2'h1) |=> !pinOe_n && pinOut == $past(altOutputs[1]))
      else $error("Selection code 1x01 did not drive alternate output one.");

   noEnable_a: assert property (@(posedge clk) disable iff (reset) // [RULE11]
      (!hwOwned && !selField[3]) |=> pinOe_n)
      else $error("Pin driven although the field enable bit is clear.");

endmodule

// [src/port_pin_function_select.sv]
// Pin function selector with start-up debug positions, input routing, RAM placement and AXI4-Lite registers.
`timescale 1ns/1ps
// Overview of operation
// RULE1: Program RAM fills upward from region base.
// RULE2: Data RAM fills downward from region top.
// RULE3: Program base E00000h, data end 00DFFFh.
// RULE4: Field code 1x00 picks output zero, onward.
// RULE5: Hardware-owned output ignores the software field.
// RULE6: Port7 bit2: GPIO, mux control; feeds position.
// RULE7: Port8 bit4: GPIO, unit outputs; feeds unit3.
// RULE8: Debug position C: port7 bit2 is TDI, pulled.
// RULE9: Debug position D: port8 bit4 is TMS, pulled.
// RULE10: System holds factory test enable high normally.
// RULE11: Field top bit enables; bit 2 ignored.
module port_pin_function_select
   import pin_select_pkg::*;
(
   // Clock and reset.
   input  wire logic                   clk,
   input  wire logic                   reset,
   // AXI4-Lite register slave.
   input  wire logic [`ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [`ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // Start-up debug position straps.
   input  wire logic                   debugSelC,
   input  wire logic                   debugSelD,
   // Pins.
   input  wire logic                   port7_bit2In,
   output logic                        port7_bit2Out,
   output logic                        port7_bit2Oe_n,
   output logic                        port7_bit2PullUp,
   input  wire logic                   port8_bit4In,
   output logic                        port8_bit4Out,
   output logic                        port8_bit4Oe_n,
   output logic                        port8_bit4PullUp,
   input  wire logic                   factory_test_enable_n,
   // Peripheral sources and sinks.
   input  wire logic                   ext_analog_mux_ctrl0,
   input  wire logic                   unit1_ch1_out,
   input  wire logic                   unit3_ch1_out,
   output logic                        unit3_position_in0,
   output logic                        unit3_ch1_in,
   output logic                        jtagTdi,
   output logic                        jtagTms,
   output logic                        factoryTestActive,
   // On-chip RAM address decode.
   input  wire mem_addr_t              memAddr,
   output logic                        programRamHit,
   output logic                        dataRamHit,
   output mem_addr_t                   ramOffset
);

   sel_field_t port7Sel;
   sel_field_t port8Sel;
   logic [1:0] gpioOut;
   ram_kb_t    progKb;
   ram_kb_t    dataKb;
   logic       strapTaken;
   logic       debugPosC;
   logic       debugPosD;
   logic [2:0] pinRaw;
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [2:0] sync3;
   logic [2:0] pinFilt;

   // Straps are caught on the first edge after release, never under reset itself.
   always_ff @(posedge clk) begin
      if (reset) begin
         strapTaken <= 1'b0;
         debugPosC  <= 1'b0;
         debugPosD  <= 1'b0;
      end else if (!strapTaken) begin
         strapTaken <= 1'b1;
         debugPosC  <= debugSelC;
         debugPosD  <= debugSelD;
      end
   end
   // Three-stage synchronisers; a level counts only once stages two and three agree.
   assign pinRaw = {factory_test_enable_n, port8_bit4In, port7_bit2In};
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (reset) begin
               sync1[gi]   <= 1'(`SYNC_RST >> gi);
               sync2[gi]   <= 1'(`SYNC_RST >> gi);
               sync3[gi]   <= 1'(`SYNC_RST >> gi);
               pinFilt[gi] <= 1'(`SYNC_RST >> gi);
            end else begin
               sync1[gi] <= pinRaw[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
               if (sync2[gi] == sync3[gi]) begin
                  pinFilt[gi] <= sync3[gi];
               end
            end
         end
      end
   endgenerate
   // Input routing; JTAG inputs idle high when their position is not chosen.
   always_ff @(posedge clk) begin
      if (reset) begin
         unit3_position_in0 <= 1'b0;
         unit3_ch1_in       <= 1'b0;
         jtagTdi            <= 1'b1;
         jtagTms            <= 1'b1;
         factoryTestActive  <= 1'b0;
      end else begin
         unit3_position_in0 <= pinFilt[0];                                // [RULE6]
         unit3_ch1_in       <= pinFilt[1];                                // [RULE7]
         jtagTdi            <= debugPosC ? pinFilt[0] : 1'b1;             // [RULE8]
         jtagTms            <= debugPosD ? pinFilt[1] : 1'b1;             // [RULE9]
         factoryTestActive  <= !pinFilt[2];                               // [RULE10]
      end
   end
   // A debug position hands the pin to hardware as an input with its pull-up on.
   assign port7_bit2PullUp = debugPosC;                                   // [RULE8]
   assign port8_bit4PullUp = debugPosD;                                   // [RULE9]
   pin_out_select u_port7 (
      .clk        (clk),           .reset   (reset),
      .selField   (port7Sel),
      .altOutputs ({2'b00, ext_analog_mux_ctrl0, gpioOut[0]}),          // [RULE6]
      .hwOwned    (debugPosC),                                            // [RULE8]
      .hwValue    (1'b0),          .hwDrive (1'b0),
      .pinOut     (port7_bit2Out), .pinOe_n (port7_bit2Oe_n)
   );
   pin_out_select u_port8 (
      .clk        (clk),           .reset   (reset),
      .selField   (port8Sel),
      .altOutputs ({1'b0, unit3_ch1_out, unit1_ch1_out, gpioOut[1]}),   // [RULE7]
      .hwOwned    (debugPosD),                                            // [RULE9]
      .hwValue    (1'b0),          .hwDrive (1'b0),
      .pinOut     (port8_bit4Out), .pinOe_n (port8_bit4Oe_n)
   );
   // RAM placement: program RAM grows up from its base, data RAM down from its end.
   // Sizes beyond the data region's span wrap and are not guarded.
   mem_addr_t progSpan;
   mem_addr_t dataBottom;
   assign progSpan   = {6'h00, progKb, 10'h000};
   assign dataBottom = `DRAM_END_NEXT - {6'h00, dataKb, 10'h000};
   always_ff @(posedge clk) begin
      if (reset) begin
         programRamHit <= 1'b0;
         dataRamHit    <= 1'b0;
         ramOffset     <= '0;
      end else begin
         programRamHit <= (memAddr >= `PRAM_BASE) && ((memAddr - `PRAM_BASE) < progSpan); // [RULE1] [RULE3]
         dataRamHit    <= (memAddr <= `DRAM_END) && (memAddr >= dataBottom) && (dataKb != '0); // [RULE2] [RULE3]
         ramOffset     <= (memAddr >= `PRAM_BASE) ? memAddr - `PRAM_BASE : memAddr - dataBottom;
      end
   end
   // AXI4-Lite write path: address and data are held separately, answered once both are in.
   logic                awHeld;
   logic                wHeld;
   logic [`ADDR_W-1:0]  awAddr;
   logic [31:0]         wData;
   logic [3:0]          wStrb;
   logic                doWrite;
   logic [`ADDR_W-1:0]  wAddrWord;
   assign s_axi_awready = !awHeld;
   assign s_axi_wready  = !wHeld;
   assign doWrite       = awHeld && wHeld && !s_axi_bvalid;
   assign wAddrWord     = {awAddr[`ADDR_W-1:2], 2'b00};
   always_ff @(posedge clk) begin
      if (reset) begin
         awHeld <= 1'b0;
         awAddr <= '0;
      end else if (s_axi_awvalid && !awHeld) begin
         awHeld <= 1'b1;
         awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
         awHeld <= 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         wHeld <= 1'b0;
         wData <= '0;
         wStrb <= '0;
      end else if (s_axi_wvalid && !wHeld) begin
         wHeld <= 1'b1;
         wData <= s_axi_wdata;
         wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
         wHeld <= 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         port7Sel <= `SEL_RST;
         port8Sel <= `SEL_RST;
         gpioOut  <= `GPIO_RST;
         progKb   <= `PRAM_KB_RST;
         dataKb   <= `DRAM_KB_RST;
      end else if (doWrite) begin
         if (wAddrWord == `REG_PORT7B2_CTRL && wStrb[0]) begin
            port7Sel <= wData[`SEL_W-1:0];
         end else if (wAddrWord == `REG_PORT8B4_CTRL && wStrb[0]) begin
            port8Sel <= wData[`SEL_W-1:0];
         end else if (wAddrWord == `REG_GPIO_OUT && wStrb[0]) begin
            gpioOut <= wData[1:0];
         end else if (wAddrWord == `REG_RAM_SIZE) begin
            if (wStrb[0]) begin
               progKb <= wData[7:0];
            end
            if (wStrb[1]) begin
               dataKb <= wData[15:8];
            end
         end
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wAddrWord <= `REG_RAM_SIZE) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
   // Read path: one answer at a time, data one cycle after the address is taken.
   logic [`ADDR_W-1:0] rAddrWord;
   assign s_axi_arready = !s_axi_rvalid;
   assign rAddrWord     = {s_axi_araddr[`ADDR_W-1:2], 2'b00};
   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `RESP_OKAY;
         if (rAddrWord == `REG_PORT7B2_CTRL) begin
            s_axi_rdata <= {28'h0000000, port7Sel};
         end else if (rAddrWord == `REG_PORT8B4_CTRL) begin
            s_axi_rdata <= {28'h0000000, port8Sel};
         end else if (rAddrWord == `REG_GPIO_OUT) begin
            s_axi_rdata <= {30'h0, gpioOut};
         end else if (rAddrWord == `REG_PIN_STATUS) begin
            s_axi_rdata <= {27'h0, debugPosD, debugPosC, !pinFilt[2], pinFilt[1], pinFilt[0]};
         end else if (rAddrWord == `REG_RAM_SIZE) begin
            s_axi_rdata <= {16'h0000, dataKb, progKb};
         end else begin
            s_axi_rdata <= '0;
            s_axi_rresp <= `RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   sequence port7SteadyHigh;
      port7_bit2In [*5];
   endsequence
   sequence port8SteadyLow;
      !port8_bit4In [*5];
   endsequence
   progBase_a: assert property (@(posedge clk) disable iff (reset) // [RULE3]
      (memAddr == `PRAM_BASE && progKb != '0) |=> programRamHit && ramOffset == '0)
      else $error("Program RAM base address not decoded as its first byte.");
   progEnd_a: assert property (@(posedge clk) disable iff (reset) // [RULE1]
      (memAddr == `PRAM_BASE + progSpan) |=> !programRamHit)
      else $error("Program RAM decoded past its implemented size.");
   dataTop_a: assert property (@(posedge clk) disable iff (reset) // [RULE2]
      (memAddr == `DRAM_END && dataKb != '0) |=> dataRamHit)
      else $error("Data RAM top address not decoded.");
   dataBelow_a: assert property (@(posedge clk) disable iff (reset) // [RULE2]
      (memAddr == dataBottom - 24'h000001) |=> !dataRamHit)
      else $error("Data RAM decoded below its implemented size.");
   positionIn_a: assert property (@(posedge clk) disable iff (reset) // [RULE6]
      port7SteadyHigh |=> ##1 unit3_position_in0)
      else $error("Port7 bit2 level did not reach the position input.");
   ch1In_a: assert property (@(posedge clk) disable iff (reset) // [RULE7]
      port8SteadyLow |=> ##1 !unit3_ch1_in)
      else $error("Port8 bit4 level did not reach the unit3 channel input.");
   tdiPull_a: assert property (@(posedge clk) disable iff (reset) // [RULE8]
      (strapTaken && debugPosC) |-> port7_bit2PullUp ##1 port7_bit2Oe_n)
      else $error("Debug position C left port7 bit2 driven or unpulled.");
   tmsPull_a: assert property (@(posedge clk) disable iff (reset) // [RULE9]
      (strapTaken && debugPosD) |-> port8_bit4PullUp ##1 port8_bit4Oe_n)
      else $error("Debug position D left port8 bit4 driven or unpulled.");
endmodule

// [test/pin_pad_model.sv]
// Pad model: resolves one pin level from the device drive, an outside driver and the pull-up.
`timescale 1ns/1ps
module pin_pad_model (
   // Clock.
   input  wire logic clk,
   // Device side of the pad.
   input  wire logic pinOut,
   input  wire logic pinOe_n,
   input  wire logic pullUp,
   // Outside driver.
   input  wire logic extDrive,
   input  wire logic extLevel,
   // Resolved pin level.
   output logic      pinLevel
);
   logic floatLevel = 1'h0;
   // A floating pin without pull toggles, so a stale level is never taken for a drive.
   always_ff @(posedge clk) begin
      floatLevel <= ~pinLevel;
   end
   always_comb begin
      if (!pinOe_n) begin
         pinLevel = pinOut;
      end else if (extDrive) begin
         pinLevel = extLevel;
      end else if (pullUp) begin
         pinLevel = 1'h1;
      end else begin
         pinLevel = floatLevel;
      end
   end
endmodule

// [test/tb.sv]
// Self-checking testbench of the pin function selector.
`timescale 1ns/1ps
`include "pin_select_consts.svh"
module tb import pin_select_pkg::*;;
   logic        clk = 1'h0, reset = 1'h1, debugSelC = 1'h0, debugSelD = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic        p7Out, p7Oe_n, p7Pull, p7Pin, p8Out, p8Oe_n, p8Pull, p8Pin, testPin;
   logic        extDrive = 1'h1, ext7Level = 1'h0, ext8Level = 1'h0, testDrive = 1'h1, testLevel = 1'h1;
   logic        ext_analog_mux_ctrl0 = 1'h0, unit1_ch1_out = 1'h0, unit3_ch1_out = 1'h0;
   logic        unit3_position_in0, unit3_ch1_in, jtagTdi, jtagTms, factoryTestActive;
   logic        programRamHit, dataRamHit;
   mem_addr_t   memAddr = 24'h0, ramOffset;
   int          n_errors = 0, check_count = 0, pKb = 32, dKb = 16;

   always #10 clk = ~clk;

   port_pin_function_select u_port_pin_function_select (
      .clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .debugSelC(debugSelC), .debugSelD(debugSelD), .port7_bit2In(p7Pin), .port7_bit2Out(p7Out),
      .port7_bit2Oe_n(p7Oe_n), .port7_bit2PullUp(p7Pull), .port8_bit4In(p8Pin), .port8_bit4Out(p8Out),
      .port8_bit4Oe_n(p8Oe_n), .port8_bit4PullUp(p8Pull), .factory_test_enable_n(testPin),
      .ext_analog_mux_ctrl0(ext_analog_mux_ctrl0), .unit1_ch1_out(unit1_ch1_out),
      .unit3_ch1_out(unit3_ch1_out), .unit3_position_in0(unit3_position_in0), .unit3_ch1_in(unit3_ch1_in),
      .jtagTdi(jtagTdi), .jtagTms(jtagTms), .factoryTestActive(factoryTestActive), .memAddr(memAddr),
      .programRamHit(programRamHit), .dataRamHit(dataRamHit), .ramOffset(ramOffset));
   pin_pad_model u_pad7 (.clk(clk), .pinOut(p7Out), .pinOe_n(p7Oe_n), .pullUp(p7Pull),
      .extDrive(extDrive), .extLevel(ext7Level), .pinLevel(p7Pin));
   pin_pad_model u_pad8 (.clk(clk), .pinOut(p8Out), .pinOe_n(p8Oe_n), .pullUp(p8Pull),
      .extDrive(extDrive), .extLevel(ext8Level), .pinLevel(p8Pin));
   // The test enable pin is input only and carries its own pull-up.
   pin_pad_model u_padTest (.clk(clk), .pinOut(1'h0), .pinOe_n(1'h1), .pullUp(1'h1),
      .extDrive(testDrive), .extLevel(testLevel), .pinLevel(testPin));

   task automatic end_sim();
      if (n_errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, input logic [3:0] strb);
      logic awDone, wDone;
      awDone = 1'h0;
      wDone = 1'h0;
      @(posedge clk);
      s_axi_awaddr <= addr;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= data;
      s_axi_wstrb <= strb;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!(awDone && wDone)) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready === 1'h1) begin
            awDone = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (s_axi_wvalid && s_axi_wready === 1'h1) begin
            wDone = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      do @(posedge clk); while (s_axi_bvalid !== 1'h1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask

   task automatic axi_read(input logic [7:0] addr);
      @(posedge clk);
      s_axi_araddr <= addr;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge clk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge clk); while (s_axi_rvalid !== 1'h1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask

   // Straps are held through reset and stay put, so the captured debug position is unambiguous.
   task automatic do_reset(input logic c, input logic d);
      @(posedge clk);
      reset <= 1'h1;
      debugSelC <= c;
      debugSelD <= d;
      repeat (3) @(posedge clk);
      reset <= 1'h0;
      settle(7);
   endtask

   task automatic drive_pins(input logic d, input logic l7, input logic l8, input logic td, input logic tl);
      @(posedge clk);
      extDrive <= d;
      ext7Level <= l7;
      ext8Level <= l8;
      testDrive <= td;
      testLevel <= tl;
      settle(6);
   endtask

   task automatic pin_case(input logic [3:0] c, input logic p);
      logic e7, e8;
      @(posedge clk);
      ext_analog_mux_ctrl0 <= ~p;
      unit1_ch1_out <= p;
      unit3_ch1_out <= ~p;
      axi_write(`REG_GPIO_OUT, {30'h0, ~p, p}, 4'h1);
      axi_write(`REG_PORT7B2_CTRL, {28'h0, c}, 4'h1);
      axi_write(`REG_PORT8B4_CTRL, {28'h0, c}, 4'h1);
      settle(3);
      e7 = (c[1:0] == 2'h0) ? p : (c[1:0] == 2'h1) ? ~p : 1'h0;
      e8 = (c[1:0] == 2'h0) ? ~p : (c[1:0] == 2'h1) ? p : (c[1:0] == 2'h2) ? ~p : 1'h0;
      check("port7_bit2Oe_n", !c[3], p7Oe_n);
      check("port8_bit4Oe_n", !c[3], p8Oe_n);
      if (c[3]) begin
         check("port7_bit2Out", e7, p7Out);
         check("port8_bit4Out", e8, p8Out);
      end
   endtask

   task automatic ram_probe(input int j);
      int pBase, dLo, a;
      logic ph, dh;
      pBase = `PRAM_BASE;
      dLo = `DRAM_END_NEXT - dKb * 1024;
      case (j)
         0: a = pBase;
         1: a = pBase + pKb * 1024 - 1;
         2: a = pBase + pKb * 1024;
         3: a = dLo - 1;
         4: a = dLo;
         5: a = `DRAM_END;
         default: a = `DRAM_END_NEXT;
      endcase
      @(posedge clk);
      memAddr <= a[23:0];
      settle(1);
      ph = (a >= pBase) && (a < pBase + pKb * 1024);
      dh = (a >= dLo) && (a <= `DRAM_END);
      check("programRamHit", ph, programRamHit);
      check("dataRamHit", dh, dataRamHit);
      if (ph || dh) check("ramOffset", ph ? a - pBase : a - dLo, ramOffset);
   endtask

   initial begin
      do_reset(1'h0, 1'h0);
      check("jtagTdi", 1'h1, jtagTdi);
      check("jtagTms", 1'h1, jtagTms);
      check("pull-ups", 2'h0, {p7Pull, p8Pull});
      for (int i = 0; i < 6; i++) begin
         axi_read(8'(i * 4));
         check("reset read data", (i == 4) ? 32'h1020 : 32'h0, rd);
         check("reset read resp", (i == 5) ? `RESP_SLVERR : `RESP_OKAY, resp);
      end
      axi_write(`REG_PIN_STATUS, 32'hFF, 4'hF);
      check("status write resp", `RESP_OKAY, resp);
      axi_write(8'h14, 32'hF, 4'hF);
      check("unmapped write resp", `RESP_SLVERR, resp);
      axi_read(`REG_PIN_STATUS);
      check("status after write", 32'h0, rd);
      for (int p = 0; p < 2; p++) begin
         for (int c = 0; c < 16; c++) begin
            pin_case(4'(c), 1'(p));
         end
      end
      axi_write(`REG_PORT7B2_CTRL, 32'h0, 4'h1);
      axi_write(`REG_PORT8B4_CTRL, 32'h0, 4'h1);
      for (int v = 1; v < 3; v++) begin
         drive_pins(1'h1, v[0], v[1], v == 1, 1'h0);
         check("unit3_position_in0", v[0], unit3_position_in0);
         check("unit3_ch1_in", v[1], unit3_ch1_in);
         check("factoryTestActive", v == 1, factoryTestActive);
         check("jtagTdi idle", 1'h1, jtagTdi);
         axi_read(`REG_PIN_STATUS);
         check("pin status", {29'h0, v == 1, v[1], v[0]}, rd);
      end
      for (int k = 0; k < 2; k++) begin
         if (k == 1) begin
            pKb = 8;
            dKb = 8;
            axi_write(`REG_RAM_SIZE, 32'h0808, 4'h3);
         end
         axi_read(`REG_RAM_SIZE);
         check("ram size", {16'h0, dKb[7:0], pKb[7:0]}, rd);
         for (int j = 0; j < 7; j++) begin
            ram_probe(j);
         end
      end
      do_reset(1'h1, 1'h1);
      axi_write(`REG_PORT7B2_CTRL, 32'h9, 4'h1);
      axi_write(`REG_PORT8B4_CTRL, 32'h9, 4'h1);
      for (int v = 0; v < 2; v++) begin
         drive_pins(v == 0, 1'h0, 1'h0, 1'h0, 1'h0);
         check("port7_bit2Oe_n", 1'h1, p7Oe_n);
         check("port8_bit4Oe_n", 1'h1, p8Oe_n);
         check("pull-ups", 2'h3, {p7Pull, p8Pull});
         check("jtagTdi", v, jtagTdi);
         check("jtagTms", v, jtagTms);
      end
      axi_read(`REG_PIN_STATUS);
      check("debug status", 32'h1B, rd);
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_sim();
   end
endmodule
